// file: logic/burst_bus_sequencer.sv
// Burst bus sequencer with its read-data FIFO
//
// What this block does
// - Instruction fetches always start as one full-line burst in line-fill order.
// - Fetch burst holds address 31..4 and select pins for every cycle.
// - Core may end a line burst early with fetch_stop; burst_last then flags the next data cycle.
// - Data cycle count follows operand length, start address and alignment.
// - Cacheable memory read becomes line fill; else burst or single cycles.
// - Unburstable multi-cycle transfers use separate cycles, each with addr_strobe.
// - Write or I/O bursts move at most four bytes in two cycles.
// - Write or I/O burst holds select pins and address 31..2.
// - Aligned write burst drives enables 0000 then 0011, last on second.
// - Odd starts and aligned three-byte operands use 0001/0011, 1001/1011, 1000/1011 pairs.
// - Non-cacheable read burst spans at most one line, line-fill order.
// - Bursts of eight bytes or less stay within one quad-word.
// - First cycle presents address 31..2 and byte_enables before data.
// - low_byte_en stays active on every line-burst data cycle; odd-start short bursts drop it on the first.
// - high_byte_en active on every line-burst cycle; short bursts ending on byte 2 drop it on the last.
// - Read is cacheable only with pcd low, lock high, cache enable low.
// - Cacheable line fill is eight two-byte data cycles.
// - Line order walks halfwords, dwords, then quad-words; last on eighth.
`default_nettype none

module seq_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,                 // Clock
    input wire logic rst_n,               // Async reset, low
    input wire logic in_valid,            // Push request
    output logic in_ready,                // Room for one word
    input wire logic [WIDTH-1:0] in_data, // Pushed word
    output logic out_valid,               // Head word present
    input wire logic out_ready,           // Consumer takes head
    output logic [WIDTH-1:0] out_data,    // Head word
    output logic [$clog2(DEPTH):0] level  // Words held in the array
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    if (DEPTH != (1 << AW)) $error("FIFO depth must be a power of two");

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    // Head register keeps the consumer side straight off a flop
    assign pop = (cnt_q != '0) && (!out_valid || out_ready);
    assign level = cnt_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem_q[rp_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module burst_bus_sequencer import burst_seq_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic sys_clk,            // 100 MHz clock
    input wire logic rst_n,              // Async reset, low
    input wire logic req_valid,          // Core offers a transfer
    output logic req_ready,              // Transfer taken when both high
    input wire logic [2:0] req_kind,     // Fetch, mem/io read/write
    input wire logic [31:0] req_addr,    // Byte start address
    input wire logic [2:0] req_len,      // Operand bytes, 1..4
    input wire logic [31:0] req_wdata,   // Write operand, low bytes
    input wire logic page_cache_disable, // Page marked uncached
    input wire logic bus_lock_n,         // Low while bus is locked
    input wire logic fetch_stop,         // End the running burst early
    output logic done,                   // Transfer finished, one pulse
    output logic rd_valid,               // Read halfword available
    input wire logic rd_ready,           // Core takes read halfword
    output logic [15:0] rd_data,         // Read halfword
    output logic [31:2] addr_out,        // Address pins 31..2
    output logic [3:0] byte_enables_n,   // Byte enables, low active
    output logic addr_strobe_n,          // Address strobe, low active
    output logic burst_last_n,           // Last data cycle, low active
    output logic mem_io_sel,             // High for memory
    output logic write_read_sel,         // High for write
    output logic data_code_sel,          // High for data
    input wire logic [15:0] data_in,     // Data pins, input side
    output logic [15:0] data_out,        // Data pins, output side
    output logic data_oe,                // Data pins driven
    input wire logic ready_n,            // Data cycle done, low active
    input wire logic cache_enable_in_n   // Cacheable answer, low active
);
    if (DEPTH < LINE_CYCLES) $error("FIFO must hold one line");

    localparam int AW = $clog2(DEPTH);

    seq_state_t st_q;
    logic [2:0] kind_q;
    logic [31:2] dw_q;
    logic [3:2] start_q;
    logic [2:0] k_q;
    logic [2:0] n_q;
    logic line_q;
    logic piece_q;
    logic two_q;
    logic stop_q;
    logic [2:0] stop_k_q;
    logic pcd_q;
    logic lock_n_q;
    logic [7:0] m_q;
    logic [63:0] wd_q;
    logic [2:0] rdy_s_q;
    logic [2:0] ken_s_q;
    logic rdy_f_q;
    logic ken_f_q;
    logic [15:0] din1_q;
    logic [15:0] din2_q;
    logic [15:0] din3_q;
    logic rdy_ev;
    logic accept;
    logic is_read;
    logic cacheable;
    logic fifo_in_ready;
    logic [AW:0] fifo_level;
    logic [3:2] a32;
    logic a1;
    logic [3:0] mp;
    logic [3:0] be;
    logic last;
    logic [7:0] acc_m;

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs: three stages, a change counts once stages two and three
    // agree. Data rides the same depth so it lines up with its ready.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_s_q <= 3'h7;
            ken_s_q <= 3'h7;
            rdy_f_q <= 1'b1;
            ken_f_q <= 1'b1;
            din1_q <= DATA_RST;
            din2_q <= DATA_RST;
            din3_q <= DATA_RST;
        end else begin
            rdy_s_q <= {rdy_s_q[1:0], ready_n};
            ken_s_q <= {ken_s_q[1:0], cache_enable_in_n};
            din1_q <= data_in;
            din2_q <= din1_q;
            din3_q <= din2_q;
            if (rdy_s_q[1] == rdy_s_q[2]) rdy_f_q <= rdy_s_q[2];
            if (ken_s_q[1] == ken_s_q[2]) ken_f_q <= ken_s_q[2];
        end
    end

    // One data cycle ends on each filtered falling edge of ready
    assign rdy_ev = (rdy_s_q[1] == rdy_s_q[2]) && !rdy_s_q[2] && rdy_f_q;

    ////////////////////////////////////////////////////////////////////////
    assign is_read = (kind_q == KIND_FETCH) || (kind_q == KIND_MEM_RD)
                     || (kind_q == KIND_IO_RD);
    assign cacheable = !pcd_q && lock_n_q && !ken_f_q;
    assign accept = req_valid && req_ready;
    assign acc_m = lane_mask(req_addr[1:0], req_len);

    // Address and enables of the current data cycle
    always_comb begin
        mp = piece_q ? m_q[7:4] : m_q[3:0];
        if (line_q) begin
            a32 = start_q ^ {k_q[2], k_q[1]};
            a1 = k_q[0];
            be = a1 ? BE_UPPER : BE_ALL;
        end else begin
            a32 = dw_q[3:2];
            a1 = (mp[1:0] == 2'h0) || k_q[0];
            be = ~mp | (a1 ? BE_UPPER : BE_ALL);
        end
        last = (k_q == n_q) || (stop_q && k_q != stop_k_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            kind_q <= KIND_FETCH;
            dw_q <= ADDR_RST;
            start_q <= 2'h0;
            k_q <= 3'h0;
            n_q <= 3'h0;
            line_q <= 1'b0;
            piece_q <= 1'b0;
            two_q <= 1'b0;
            pcd_q <= 1'b0;
            lock_n_q <= 1'b1;
            m_q <= 8'h0;
            wd_q <= 64'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (accept) begin
                        kind_q <= req_kind;
                        dw_q <= req_addr[31:2];
                        start_q <= req_addr[3:2];
                        k_q <= 3'h0;
                        line_q <= req_kind == KIND_FETCH;
                        // Length, offset and alignment fix the cycles
                        n_q <= (req_kind == KIND_FETCH) ? LINE_LAST
                             : {2'h0, both_halves(acc_m[3:0])};
                        two_q <= (req_kind != KIND_FETCH)
                                 && (acc_m[7:4] != 4'h0);
                        piece_q <= 1'b0;
                        m_q <= acc_m;
                        pcd_q <= page_cache_disable;
                        lock_n_q <= bus_lock_n;
                        wd_q <= {32'h0, req_wdata} << {req_addr[1:0], 3'h0};
                        st_q <= S_STROBE;
                    end
                end
                S_STROBE: st_q <= S_WAIT;
                S_WAIT: begin
                    if (rdy_ev) begin
                        if (k_q == 3'h0 && !line_q && cacheable
                            && kind_q == KIND_MEM_RD) begin
                            // Switch to a line fill from this dword
                            line_q <= 1'b1;
                            start_q <= dw_q[3:2];
                            n_q <= LINE_LAST;
                            two_q <= 1'b0;
                            k_q <= 3'h1;
                        end else if (last && two_q && !piece_q) begin
                            // Crossing a dword: a fresh strobed cycle
                            piece_q <= 1'b1;
                            dw_q <= dw_q + 30'h1;
                            k_q <= 3'h0;
                            n_q <= {2'h0, both_halves(m_q[7:4])};
                            st_q <= S_STROBE;
                        end else if (last) begin
                            st_q <= S_IDLE;
                            done <= 1'b1;
                        end else begin
                            k_q <= k_q + 3'h1;
                        end
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // Early end request; only meaningful while a line burst runs. It ends
    // the next data cycle, so burst_last is on the pins before that cycle
    // is answered; ending the running one would flag it too late.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q <= 1'b0;
            stop_k_q <= 3'h0;
        end else if (accept) begin
            stop_q <= 1'b0;
        end else if (fetch_stop && line_q && st_q != S_IDLE && !stop_q) begin
            stop_q <= 1'b1;
            stop_k_q <= k_q;
        end
    end

    // A read is only started with a whole line of room, since the bus
    // cannot be stalled once data cycles run.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (st_q == S_IDLE) && !accept
                         && (fifo_level <= (AW+1)'(DEPTH - LINE_CYCLES));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins, registered from the current cycle's state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_out <= ADDR_RST;
            byte_enables_n <= 4'hF;
            addr_strobe_n <= 1'b1;
            burst_last_n <= 1'b1;
            mem_io_sel <= 1'b0;
            write_read_sel <= 1'b0;
            data_code_sel <= 1'b0;
            data_out <= DATA_RST;
            data_oe <= 1'b0;
        end else begin
            addr_out <= {dw_q[31:4], a32};
            byte_enables_n <= (st_q == S_IDLE) ? 4'hF : be;
            addr_strobe_n <= st_q != S_STROBE;
            burst_last_n <= !(st_q == S_WAIT && last);
            mem_io_sel <= kind_q != KIND_IO_RD && kind_q != KIND_IO_WR;
            write_read_sel <= kind_q == KIND_MEM_WR || kind_q == KIND_IO_WR;
            data_code_sel <= kind_q != KIND_FETCH;
            data_out <= wd_q[{piece_q, a1, 4'h0} +: 16];
            data_oe <= (st_q != S_IDLE) && !is_read;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    seq_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_rd_fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(st_q == S_WAIT && rdy_ev && is_read),
        .in_ready(fifo_in_ready),
        .in_data(din3_q),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data),
        .level(fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_fetch_line: assert property (
        accept && req_kind == KIND_FETCH |=> line_q && n_q == LINE_LAST)
        else $error("fetch did not start a line burst");
    chk_sel_hold: assert property (
        st_q == S_WAIT && $past(st_q) == S_WAIT |->
        $stable(addr_out[31:4]) && $stable(mem_io_sel)
        && $stable(write_read_sel) && $stable(data_code_sel))
        else $error("address or select pins moved inside a burst");
    chk_early_end: assert property (
        stop_q && k_q != stop_k_q && st_q == S_WAIT |=> !burst_last_n)
        else $error("early end did not raise burst_last");
    chk_two_cycle: assert property (
        st_q == S_WAIT && !line_q |-> n_q <= 3'h1 && k_q <= 3'h1)
        else $error("short burst longer than two cycles");
    chk_quad_hold: assert property (
        st_q == S_WAIT && !line_q && $past(st_q) == S_WAIT
        && $past(!line_q) |-> $stable(addr_out))
        else $error("short burst left its quad-word");
    chk_second_be: assert property (
        st_q == S_WAIT && !line_q && k_q == 3'h1 |=>
        byte_enables_n[1:0] == 2'h3 && !burst_last_n)
        else $error("second cycle enables or last wrong");
    chk_low_lane: assert property (
        st_q == S_WAIT && line_q |=> !byte_enables_n[0]
        || !byte_enables_n[2])
        else $error("low byte lane dropped in burst");
    chk_high_lane: assert property (
        st_q == S_WAIT && line_q |=> !byte_enables_n[1]
        || !byte_enables_n[3])
        else $error("high byte lane dropped in burst");
    chk_fill_cacheable: assert property (
        $rose(line_q) && kind_q == KIND_MEM_RD |->
        $past(!pcd_q && lock_n_q && !ken_f_q))
        else $error("line fill without cacheable answer");
    chk_eighth_last: assert property (
        st_q == S_WAIT && line_q && k_q == LINE_LAST && !stop_q |=>
        !burst_last_n ##1 1'b1)
        else $error("line fill last cycle not flagged");
    chk_strobe_once: assert property (
        st_q == S_STROBE |=> !addr_strobe_n ##1 addr_strobe_n)
        else $error("address strobe not one cycle");
    chk_no_overflow: assert property (
        st_q == S_WAIT && rdy_ev && is_read |-> fifo_in_ready)
        else $error("read data pushed into full FIFO");

    cov_line_fill: cover property (
        line_q && k_q == LINE_LAST && rdy_ev ##1 done);
    cov_early_stop: cover property (stop_q && st_q == S_WAIT ##1 done);
    cov_split: cover property ($rose(piece_q));
endmodule

`default_nettype wire

// file: logic/burst_seq_pkg.sv
// Shared constants, kinds and state type for the burst bus sequencer
`default_nettype none
package burst_seq_pkg;
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int LINE_CYCLES = 8;
    localparam logic [2:0] LINE_LAST = 3'h7;
    localparam logic [2:0] KIND_FETCH = 3'h0;
    localparam logic [2:0] KIND_MEM_RD = 3'h1;
    localparam logic [2:0] KIND_MEM_WR = 3'h2;
    localparam logic [2:0] KIND_IO_RD = 3'h3;
    localparam logic [2:0] KIND_IO_WR = 3'h4;
    // Active-low byte enables: all lanes, and upper halfword only
    localparam logic [3:0] BE_ALL = 4'h0;
    localparam logic [3:0] BE_UPPER = 4'h3;
    localparam logic [31:2] ADDR_RST = 30'h0;
    localparam logic [15:0] DATA_RST = 16'h0;

    typedef enum logic [1:0] {S_IDLE, S_STROBE, S_WAIT} seq_state_t;

    // Byte lanes touched across two dwords, from offset and length 1..4
    function automatic logic [7:0] lane_mask(input logic [1:0] off,
                                             input logic [2:0] len);
        logic [7:0] base;
        base = 8'h0F;
        case (len)
            3'h1: base = 8'h01;
            3'h2: base = 8'h03;
            3'h3: base = 8'h07;
            default: base = 8'h0F;
        endcase
        return base << off;
    endfunction

    // A piece needs two data cycles when both halfwords carry data
    function automatic logic both_halves(input logic [3:0] m);
        return (m[1:0] != 2'h0) && (m[3:2] != 2'h0);
    endfunction
endpackage
`default_nettype wire

// file: tb/bus_ctrl_model.sv
// Memory and I/O controller model answering the sequencer's data cycles
`default_nettype none
module bus_ctrl_model (
    input wire logic sys_clk,              // Clock
    input wire logic rst_n,                // Reset, low
    input wire logic [31:2] addr_out,      // Address pins
    input wire logic [3:0] byte_enables_n, // Lane enables
    input wire logic addr_strobe_n,        // Transfer start
    input wire logic burst_last_n,         // Last data cycle
    input wire logic slow,                 // Insert wait states
    input wire logic cacheable,            // Claim cacheable
    output logic [15:0] data_in,           // Read data
    output logic ready_n,                  // Data cycle end
    output logic cache_enable_in_n,        // Cacheable answer
    output logic beat                      // Pins valid this cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] a;
    logic more;
    logic [3:2] latched_addr;
    logic [7:1] pred_addr;
    logic [2:0] cyc;
    logic start1;
    assign cache_enable_in_n = !cacheable;
    // Every read gets an answer, used or not, so overrun prefetch is legal
    initial begin
        ready_n = 1'b1;
        data_in = 16'h5A5A;
        beat = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (rst_n && !addr_strobe_n) begin
                more = 1'b1;
                cyc = 3'h0;
                while (more) begin
                    repeat (slow ? 7 : 3) @(posedge sys_clk);
                    #1;
                    if (cyc == 3'h0) begin
                        latched_addr = addr_out[3:2];
                        start1 = &byte_enables_n[1:0];
                    end
                    // Data answers the predicted address, so a bad order shows
                    pred_addr[7:4] = addr_out[7:4];
                    pred_addr[3:2] = latched_addr ^ {cyc[2], cyc[1]};
                    pred_addr[1] = burst_last_n ? start1 ^ cyc[0]
                        : &byte_enables_n[1:0];
                    a = {pred_addr, 1'b0};
                    cyc = cyc + 3'h1;
                    data_in = {a + 8'h01, a};
                    @(posedge sys_clk) #1 ready_n = 1'b0;
                    beat = 1'b1;
                    more = burst_last_n;
                    @(posedge sys_clk) #1 beat = 1'b0;
                    @(posedge sys_clk) #1 ready_n = 1'b1;
                    // Released bus shows a changed value, never the old one
                    @(posedge sys_clk) #1 data_in = ~data_in;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/burst_bus_sequencer_test.sv
// Testbench for the burst bus sequencer against the controller model
`default_nettype none
module burst_bus_sequencer_test import burst_seq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0] kind;
        logic [31:0] addr;
        logic [2:0] len;
        logic [2:0] ctl;
        int beats;
        int strobes;
    } row_t;
    logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, rd_ready = 1'b0;
    logic page_cache_disable = 1'b0, bus_lock_n = 1'b1, fetch_stop = 1'b0;
    logic slow = 1'b0, cacheable = 1'b0;
    logic [2:0] req_kind = 3'h0, req_len = 3'h4;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'hA1B2C3D4;
    logic req_ready, done, rd_valid, addr_strobe_n, burst_last_n, data_oe;
    logic mem_io_sel, write_read_sel, data_code_sel, ready_n, beat;
    logic cache_enable_in_n;
    logic [15:0] rd_data, data_in, data_out;
    logic [31:2] addr_out;
    logic [3:0] byte_enables_n;
    logic [63:0] obs[$], exp_q[$], msk_q[$];
    logic [15:0] exp_rd[$];
    int n_mismatch = 0, n_checks = 0, n_strobe = 0;
    // Control field is {page_cache_disable, bus_lock_n, cacheable}
    row_t rows[13] = '{
        '{KIND_FETCH, 32'h100, 3'h4, 3'h2, 8, 1},
        '{KIND_FETCH, 32'h10C, 3'h2, 3'h6, 8, 1},
        '{KIND_MEM_RD, 32'h208, 3'h4, 3'h3, 8, 1},
        '{KIND_MEM_RD, 32'h208, 3'h4, 3'h7, 2, 1},
        '{KIND_MEM_RD, 32'h208, 3'h4, 3'h1, 2, 1},
        '{KIND_MEM_RD, 32'h204, 3'h1, 3'h2, 1, 1},
        '{KIND_MEM_WR, 32'h300, 3'h4, 3'h2, 2, 1},
        '{KIND_MEM_WR, 32'h301, 3'h4, 3'h2, 3, 2},
        '{KIND_IO_WR, 32'h305, 3'h2, 3'h2, 2, 1},
        '{KIND_IO_RD, 32'h306, 3'h2, 3'h2, 1, 1},
        '{KIND_MEM_WR, 32'h30A, 3'h3, 3'h2, 2, 2},
        '{KIND_IO_RD, 32'h30C, 3'h4, 3'h3, 2, 1},
        '{KIND_IO_WR, 32'h303, 3'h1, 3'h2, 1, 1}};

    always #5 sys_clk = ~sys_clk;

    burst_bus_sequencer i_dut (.sys_clk, .rst_n, .req_valid, .req_ready,
        .req_kind, .req_addr, .req_len, .req_wdata, .page_cache_disable,
        .bus_lock_n, .fetch_stop, .done, .rd_valid, .rd_ready, .rd_data,
        .addr_out, .byte_enables_n, .addr_strobe_n, .burst_last_n,
        .mem_io_sel, .write_read_sel, .data_code_sel, .data_in, .data_out,
        .data_oe, .ready_n, .cache_enable_in_n);
    bus_ctrl_model i_ctrl (.sys_clk, .rst_n, .addr_out, .byte_enables_n,
        .addr_strobe_n, .burst_last_n, .slow, .cacheable, .data_in, .ready_n,
        .cache_enable_in_n, .beat);

    always @(posedge sys_clk) begin
        if (beat)
            obs.push_back({9'h0, addr_out, byte_enables_n, burst_last_n,
                mem_io_sel, write_read_sel, data_code_sel, data_oe, data_out});
        if (rst_n && !addr_strobe_n)
            n_strobe++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(logic [63:0] got, logic [63:0] want);
        n_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD at %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic check_count(int got, int want);
        n_checks++;
        if (got != want) begin
            n_mismatch++;
            $display("BAD at %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Waits at least one edge, so a request is really taken on return
    task automatic wait_hi(ref logic s, input int lim);
        int t;
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (s !== 1'b1 && t < lim);
        check(64'(s === 1'b1), 64'h1);
        #1;
    endtask
    function automatic void push(logic [31:2] a, logic [3:0] be,
            logic lastn, logic [31:0] w, logic [2:0] kd);
        logic wr;
        logic hi;
        logic [1:0] en;
        logic [7:0] b;
        wr = kd == KIND_MEM_WR || kd == KIND_IO_WR;
        hi = &be[1:0];
        en = hi ? ~be[3:2] : ~be[1:0];
        b = {a[7:2], hi, 1'b0};
        exp_rd.push_back({b + 8'h01, b});
        msk_q.push_back({9'h0, 39'h7FFFFFFFFF, {8{wr & en[1]}},
            {8{wr & en[0]}}});
        exp_q.push_back({9'h0, a, be, lastn, kd != KIND_IO_RD &&
            kd != KIND_IO_WR, wr, kd != KIND_FETCH, wr,
            (hi ? w[31:16] : w[15:0]) & msk_q[$][15:0]});
    endfunction
    task automatic build(row_t r);
        logic [7:0] m;
        logic [3:0] l;
        logic [63:0] w;
        logic two;
        exp_q.delete();
        msk_q.delete();
        exp_rd.delete();
        if (r.kind == KIND_FETCH || (r.kind == KIND_MEM_RD && r.ctl == 3'h3))
            for (int k = 0; k < LINE_CYCLES; k++)
                push({r.addr[31:4], r.addr[3:2] ^ 2'(k >> 1)},
                    k[0] ? BE_UPPER : BE_ALL, k != 7, 32'h0, r.kind);
        else begin
            m = 8'(((9'h1 << r.len) - 9'h1) << r.addr[1:0]);
            w = 64'(req_wdata) << (8 * r.addr[1:0]);
            for (int j = 0; j < 2; j++) begin
                l = m[4 * j +: 4];
                two = (l[1:0] != 2'h0) && (l[3:2] != 2'h0);
                if (l != 4'h0)
                    push(r.addr[31:2] + 30'(j), ~l, two, w[32 * j +: 32],
                        r.kind);
                if (two)
                    push(r.addr[31:2] + 30'(j), ~l | BE_UPPER, 1'b0,
                        w[32 * j +: 32], r.kind);
            end
        end
    endtask
    // Consumer stalls a cycle between words
    task automatic drain(int n);
        for (int i = 0; i < n; i++) begin
            wait_hi(rd_valid, 100);
            check(64'(rd_data), 64'(exp_rd[i % exp_rd.size()]));
            rd_ready = 1'b1;
            @(posedge sys_clk) #1 rd_ready = 1'b0;
        end
    endtask
    task automatic run(row_t r, bit drain_it);
        build(r);
        obs.delete();
        n_strobe = 0;
        {page_cache_disable, bus_lock_n, cacheable} = r.ctl;
        req_kind = r.kind;
        req_addr = r.addr;
        req_len = r.len;
        req_valid = 1'b1;
        wait_hi(req_ready, 300);
        req_valid = 1'b0;
        wait_hi(done, 3000);
        if (r.beats > 0)
            check_count(obs.size(), r.beats);
        check_count(n_strobe, r.strobes);
        for (int k = 0; k < obs.size() - (r.beats == 0); k++)
            check(obs[k] & msk_q[k], exp_q[k]);
        if (drain_it && r.kind inside {KIND_FETCH, KIND_MEM_RD, KIND_IO_RD})
            drain(obs.size());
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check(64'({req_ready, done, rd_valid, addr_strobe_n, burst_last_n,
            data_oe, byte_enables_n, addr_out}), 64'({6'h06, 4'hF, 30'h0}));
        rst_n = 1'b1;
        wait_hi(req_ready, 3);
    endtask

    initial begin
        #300000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        for (int i = 0; i < $size(rows); i++) begin
            slow = i[0];
            run(rows[i], 1'b1);
            $display("row %0d finished", i);
        end
        do_reset();
        $display("reset test finished");
        fork
            run('{KIND_FETCH, 32'h404, 3'h4, 3'h2, 0, 1}, 1'b1);
            begin
                wait_hi(beat, 300);
                wait_hi(beat, 300);
                fetch_stop = 1'b1;
            end
        join
        fetch_stop = 1'b0;
        check(64'(obs.size() < 8), 64'h1);
        check(64'(obs[$][20]), 64'h0);
        $display("early end test finished");
        for (int i = 0; i < 4; i++)
            run(rows[0], 1'b0);
        req_valid = 1'b1;
        repeat (20)
            @(posedge sys_clk) check(64'(req_ready), 64'h0);
        #1 req_valid = 1'b0;
        drain(32);
        run(rows[0], 1'b1);
        $display("buffer test finished");
        tally_and_finish();
    end
endmodule
`default_nettype wire
